//--- verilog/flash_guard_pkg.sv
// Shared constants and types of the flash security access guard.
package flash_guard_pkg;

   // -------------------------------------------------------------------
   // Address map
   // -------------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int PAGE_SHIFT = 10;
   localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
   localparam logic [15:0] SCRATCH_LAST = 16'h03FF;
   localparam logic [15:0] LOCK_BYTE_ADDR = 16'hFBFF;
   localparam logic [15:0] RESERVED_BASE = 16'hFC00;
   localparam logic [15:0] PART_ID_ADDR = 16'hFFFE;
   localparam logic [5:0] LOCK_PAGE = LOCK_BYTE_ADDR[15:10];

   // -------------------------------------------------------------------
   // Codes and values after reset
   // -------------------------------------------------------------------
   localparam logic [7:0] KEY_FIRST = 8'hA5;
   localparam logic [7:0] KEY_SECOND = 8'hF1;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // All pages count as locked until the lock byte has been sampled.
   localparam logic [7:0] LOCK_SAFE = 8'h00;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   // Request codes; bit 2 set marks the debug port as requester.
   typedef enum logic [2:0] {
      OP_FETCH = 3'h0,
      OP_CODE_RD = 3'h1,
      OP_EXT_RD = 3'h2,
      OP_EXT_WR = 3'h3,
      OP_DBG_RD = 3'h4,
      OP_DBG_WR = 3'h5,
      OP_DBG_ERASE = 3'h6,
      OP_DBG_FULL = 3'h7
   } op_t;

   typedef enum logic [1:0] {
      KIND_READ = 2'h0,
      KIND_WRITE = 2'h1,
      KIND_ERASE = 2'h2,
      KIND_FULL = 2'h3
   } kind_t;

   typedef enum logic [1:0] {
      TGT_NONE = 2'h0,
      TGT_FLASH = 2'h1,
      TGT_SCRATCH = 2'h2,
      TGT_XRAM = 2'h3
   } target_t;

   typedef enum logic [3:0] {
      KEY_IDLE = 4'h1,
      KEY_HALF = 4'h2,
      KEY_ARMED = 4'h4,
      KEY_DEAD = 4'h8
   } key_t;

endpackage

//--- verilog/flash_security_access_guard.sv
// Access guard that grants, ignores or punishes each flash request.
//
// Contract
// - Scratchpad replaces low page when selected
// - Scratchpad never serves instruction fetches
// - External reads go to RAM only
// - Write needs write enable; erase needs both
// - Inverted lock byte counts locked low pages
// - Lock byte page locked if any bit zero
// - Unlocked pages open to every requester
// - Locked pages: debug refused, unlocked code resets
// - Lock page access gated like locked pages
// - Lock byte read gated like locked pages
// - Firmware lock page erase always resets
// - Full erase clears flash and scratchpad
// - Written lock byte changes only by full erase, or by debug page erase while the lock in force is all ones
// - Reserved area refused or resets, except part code reads and fetches
// - Error reset leaves error flag set
// - Debug port violations ignored, never reset
// - New lock setting waits for device reset
// - Scratchpad locked when all pages locked
// - Part code returned at address FFFE
// - Firmware modify without supply monitor resets device
// - Key sequence arms; wrong key disables
// - Every completed firmware modify disarms the key
// - Erase whole page; writes only clear bits
`timescale 1ns/100ps

module flash_security_access_guard #(
   parameter int ADDR_W = 16,
   parameter logic [7:0] PART_ID = 8'h3C // Arbitrary value.
) (
   input logic clk_i,
   input logic rst_i,
   input logic sys_reset_i,
   input logic req_i,
   input flash_guard_pkg::op_t op_i,
   input logic [15:0] addr_i,
   input logic [7:0] wr_data_i,
   input logic [7:0] old_data_i,
   input logic [15:0] exec_addr_i,
   input logic scratchpad_select_i,
   input logic store_write_enable_i,
   input logic store_erase_enable_i,
   input logic supply_monitor_en_i,
   input logic supply_monitor_reset_en_i,
   input logic [7:0] lock_byte_i,
   input logic key_wr_i,
   input logic [7:0] key_data_i,
   output logic grant_o,
   output logic ignored_o,
   output logic flash_error_reset_o,
   output logic debug_port_full_erase_o,
   output flash_guard_pkg::kind_t kind_o,
   output flash_guard_pkg::target_t target_o,
   output logic [15:0] addr_o,
   output logic [7:0] wr_data_o,
   output logic id_valid_o,
   output logic [7:0] id_data_o,
   output logic flash_error_flag_o,
   output logic key_armed_o,
   output logic [7:0] locked_pages_o
);

   // -------------------------------------------------------------------
   // Elaboration check
   // -------------------------------------------------------------------
   // The page and area decode is built for a 64 kB code space only.
   if (ADDR_W != flash_guard_pkg::ADDR_W) begin : g_bad_width
      $error("flash guard supports a 16-bit address only");
   end

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      flash_guard_pkg::key_t key; // Key sequence progress.
      logic loaded; // Lock byte sampled since release.
      logic [7:0] lock; // Lock byte in force.
      logic pend; // Error reset issued, awaiting reset.
      logic flag; // Error flag seen after reset.
      logic grant; // Request carried out.
      logic ignore; // Request silently dropped.
      logic err; // Error reset request.
      logic full; // Full erase strobe.
      flash_guard_pkg::kind_t kind;
      flash_guard_pkg::target_t tgt;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic id_vld;
      logic [7:0] id;
   } state_t;

   localparam state_t STATE_RST = '{
      key: flash_guard_pkg::KEY_IDLE, loaded: 1'b0, lock: flash_guard_pkg::LOCK_SAFE,
      pend: 1'b0, flag: 1'b0, grant: 1'b0, ignore: 1'b0, err: 1'b0, full: 1'b0,
      kind: flash_guard_pkg::KIND_READ, tgt: flash_guard_pkg::TGT_NONE, addr: 16'h0000,
      wdata: 8'h00, id_vld: 1'b0, id: 8'h00
   };

   state_t state_ff; // Registered state.
   state_t nxt_state; // Next state from the decision logic.

   // -------------------------------------------------------------------
   // Lock decode
   // -------------------------------------------------------------------
   logic [7:0] lock_count; // Number of locked low pages.
   logic any_lock; // Any page locked at all.
   logic [7:0] req_page; // Page of the requested address.
   logic [7:0] exec_page; // Page of the running instruction.
   logic page_locked; // Requested ordinary page is locked.
   logic scratch_locked; // Scratchpad counts as locked.
   logic exec_locked; // Firmware runs from a locked page.
   logic lock_pg; // Request hits the lock byte page.
   logic in_reserved; // Request hits the reserved area.
   logic supply_ok; // Supply monitor guards the device.

   assign lock_count = ~state_ff.lock;
   assign any_lock = (lock_count != 8'h00);
   assign req_page = {2'h0, addr_i[15:flash_guard_pkg::PAGE_SHIFT]};
   assign exec_page = {2'h0, exec_addr_i[15:flash_guard_pkg::PAGE_SHIFT]};
   assign page_locked = (req_page < lock_count);
   // The scratchpad follows only once every other page is locked.
   assign scratch_locked = (lock_count >= {2'h0, flash_guard_pkg::LOCK_PAGE});
   // Code in the lock byte page runs as locked code once anything is locked.
   assign exec_locked = (exec_page < lock_count) ||
      ((exec_page[5:0] == flash_guard_pkg::LOCK_PAGE) && any_lock);
   assign lock_pg = (addr_i[15:10] == flash_guard_pkg::LOCK_PAGE);
   assign in_reserved = (addr_i >= flash_guard_pkg::RESERVED_BASE);
   assign supply_ok = supply_monitor_en_i && supply_monitor_reset_en_i;

   // -------------------------------------------------------------------
   // Decision logic
   // -------------------------------------------------------------------
   // Decodes each request to its kind and target, checks it against the
   // lock state in force and picks grant, silent drop or error reset.
   always_comb begin
      flash_guard_pkg::kind_t kind;
      flash_guard_pkg::target_t tgt;
      logic dbg, is_id, modify, area_locked, bad, fw_err;
      kind = flash_guard_pkg::KIND_READ;
      tgt = flash_guard_pkg::TGT_FLASH;
      dbg = op_i[2];
      is_id = 1'b0;
      modify = 1'b0;
      area_locked = 1'b0;
      bad = 1'b0;
      fw_err = 1'b0;
      nxt_state = state_ff;
      nxt_state.grant = 1'b0;
      nxt_state.ignore = 1'b0;
      nxt_state.err = 1'b0;
      nxt_state.full = 1'b0;
      nxt_state.id_vld = 1'b0;

      // Request decode.
      unique case (op_i)
         flash_guard_pkg::OP_FETCH, flash_guard_pkg::OP_CODE_RD, flash_guard_pkg::OP_DBG_RD: begin
            tgt = flash_guard_pkg::TGT_FLASH;
         end
         flash_guard_pkg::OP_EXT_RD: begin
            tgt = flash_guard_pkg::TGT_XRAM;
         end
         flash_guard_pkg::OP_EXT_WR: begin
            // Without write enable the store goes to RAM as usual.
            if (!store_write_enable_i) begin
               kind = flash_guard_pkg::KIND_WRITE;
               tgt = flash_guard_pkg::TGT_XRAM;
            end else if (store_erase_enable_i) begin
               kind = flash_guard_pkg::KIND_ERASE;
            end else begin
               kind = flash_guard_pkg::KIND_WRITE;
            end
         end
         flash_guard_pkg::OP_DBG_WR: begin
            kind = flash_guard_pkg::KIND_WRITE;
         end
         flash_guard_pkg::OP_DBG_ERASE: begin
            kind = flash_guard_pkg::KIND_ERASE;
         end
         flash_guard_pkg::OP_DBG_FULL: begin
            kind = flash_guard_pkg::KIND_FULL;
         end
      endcase

      // Data accesses to the low page move to the scratchpad.
      if (scratchpad_select_i && (addr_i <= flash_guard_pkg::SCRATCH_LAST) &&
          (tgt == flash_guard_pkg::TGT_FLASH) && (op_i != flash_guard_pkg::OP_FETCH) &&
          (kind != flash_guard_pkg::KIND_FULL)) begin
         tgt = flash_guard_pkg::TGT_SCRATCH;
      end
      is_id = (addr_i == flash_guard_pkg::PART_ID_ADDR) && (kind == flash_guard_pkg::KIND_READ) &&
         ((op_i == flash_guard_pkg::OP_CODE_RD) || (op_i == flash_guard_pkg::OP_DBG_RD));
      modify = (kind == flash_guard_pkg::KIND_WRITE) || (kind == flash_guard_pkg::KIND_ERASE);
      // Scratchpad, lock byte page and ordinary pages lock differently.
      if (tgt == flash_guard_pkg::TGT_SCRATCH) begin
         area_locked = scratch_locked;
      end else if (lock_pg) begin
         area_locked = any_lock;
      end else begin
         area_locked = page_locked;
      end

      // Violations that nobody may commit, whatever page code runs from.
      bad = (in_reserved && !is_id) ||
         ((kind == flash_guard_pkg::KIND_WRITE) && (tgt == flash_guard_pkg::TGT_FLASH) &&
          (addr_i == flash_guard_pkg::LOCK_BYTE_ADDR) &&
          (lock_byte_i != flash_guard_pkg::ERASED_BYTE));
      fw_err = bad || (area_locked && !exec_locked) ||
         ((kind == flash_guard_pkg::KIND_ERASE) && lock_pg &&
          (tgt == flash_guard_pkg::TGT_FLASH)) ||
         (modify && !supply_ok);

      // Key sequence; a request in the same cycle overrides it below.
      if (key_wr_i) begin
         unique case (state_ff.key)
            flash_guard_pkg::KEY_IDLE: begin
               nxt_state.key = (key_data_i == flash_guard_pkg::KEY_FIRST) ?
                  flash_guard_pkg::KEY_HALF : flash_guard_pkg::KEY_DEAD;
            end
            flash_guard_pkg::KEY_HALF: begin
               nxt_state.key = (key_data_i == flash_guard_pkg::KEY_SECOND) ?
                  flash_guard_pkg::KEY_ARMED : flash_guard_pkg::KEY_DEAD;
            end
            flash_guard_pkg::KEY_ARMED, flash_guard_pkg::KEY_DEAD: begin
               // A third code is out of order and kills the key; dead stays dead.
               nxt_state.key = flash_guard_pkg::KEY_DEAD;
            end
         endcase
      end

      // The lock byte is sampled once after power-on release.
      if (!state_ff.loaded) begin
         nxt_state.lock = lock_byte_i;
         nxt_state.loaded = 1'b1;
      end

      // A request in the cycle of a device reset is dropped unreported.
      if (req_i && !sys_reset_i) begin
         nxt_state.kind = kind;
         nxt_state.tgt = tgt;
         nxt_state.addr = addr_i;
         // Flash cells can only lose ones, so the old byte masks the new.
         if ((kind == flash_guard_pkg::KIND_WRITE) && (tgt != flash_guard_pkg::TGT_XRAM)) begin
            nxt_state.wdata = wr_data_i & old_data_i;
         end else begin
            nxt_state.wdata = wr_data_i;
         end
         if (is_id) begin
            nxt_state.grant = 1'b1;
            nxt_state.id_vld = 1'b1;
            nxt_state.id = PART_ID;
         end else if ((tgt == flash_guard_pkg::TGT_XRAM) ||
                      (op_i == flash_guard_pkg::OP_FETCH)) begin
            nxt_state.grant = 1'b1;
         end else if (kind == flash_guard_pkg::KIND_FULL) begin
            // Clears every page, lock byte page and scratchpad alike.
            nxt_state.grant = 1'b1;
            nxt_state.full = 1'b1;
         end else if (dbg) begin
            // The debug port is never allowed to reset the device.
            if (bad || area_locked) begin
               nxt_state.ignore = 1'b1;
            end else begin
               nxt_state.grant = 1'b1;
            end
         end else if (fw_err) begin
            nxt_state.err = 1'b1;
            nxt_state.pend = 1'b1;
         end else if (modify) begin
            if (state_ff.key == flash_guard_pkg::KEY_ARMED) begin
               nxt_state.grant = 1'b1;
               nxt_state.key = flash_guard_pkg::KEY_IDLE;
            end else begin
               // Modifying without a complete key disables it until the next device reset.
               nxt_state.ignore = 1'b1;
               nxt_state.key = flash_guard_pkg::KEY_DEAD;
            end
         end else begin
            nxt_state.grant = 1'b1;
         end
      end

      // A device reset applies the lock written meanwhile and reports why.
      if (sys_reset_i) begin
         nxt_state.lock = lock_byte_i;
         nxt_state.loaded = 1'b1;
         nxt_state.key = flash_guard_pkg::KEY_IDLE;
         nxt_state.flag = state_ff.pend;
         nxt_state.pend = 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   // Power-on reset clears all, including the error flag.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= STATE_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Every output comes from the state flip-flops; key_armed_o and locked_pages_o are decoded from them.
   assign grant_o = state_ff.grant;
   assign ignored_o = state_ff.ignore;
   assign flash_error_reset_o = state_ff.err;
   assign debug_port_full_erase_o = state_ff.full;
   assign kind_o = state_ff.kind;
   assign target_o = state_ff.tgt;
   assign addr_o = state_ff.addr;
   assign wr_data_o = state_ff.wdata;
   assign id_valid_o = state_ff.id_vld;
   assign id_data_o = state_ff.id;
   assign flash_error_flag_o = state_ff.flag;
   assign key_armed_o = (state_ff.key == flash_guard_pkg::KEY_ARMED);
   assign locked_pages_o = ~state_ff.lock;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ext_read_ram: assert property (
      req_i && !sys_reset_i && (op_i == flash_guard_pkg::OP_EXT_RD) |=>
      grant_o && (target_o == flash_guard_pkg::TGT_XRAM))
      else $error("external read not sent to RAM");
   a_fetch_flash: assert property (
      req_i && !sys_reset_i && (op_i == flash_guard_pkg::OP_FETCH) |=>
      (target_o == flash_guard_pkg::TGT_FLASH))
      else $error("fetch served from scratchpad");
   a_scratch_map: assert property (
      req_i && !sys_reset_i && (op_i == flash_guard_pkg::OP_CODE_RD) && scratchpad_select_i &&
      (addr_i <= flash_guard_pkg::SCRATCH_LAST) |=> (target_o == flash_guard_pkg::TGT_SCRATCH))
      else $error("scratchpad not mapped");
   a_no_enable_ram: assert property (
      req_i && !sys_reset_i && (op_i == flash_guard_pkg::OP_EXT_WR) && !store_write_enable_i |=>
      (target_o == flash_guard_pkg::TGT_XRAM))
      else $error("flash written without write enable");
   a_debug_no_reset: assert property (
      req_i && op_i[2] |=> !flash_error_reset_o)
      else $error("debug request caused error reset");
   a_supply_reset: assert property (
      req_i && !sys_reset_i && (op_i == flash_guard_pkg::OP_EXT_WR) && store_write_enable_i &&
      !(supply_monitor_en_i && supply_monitor_reset_en_i) |=> flash_error_reset_o && !grant_o)
      else $error("modify without supply monitor not punished");
   a_key_disarm: assert property (
      grant_o && (kind_o == flash_guard_pkg::KIND_WRITE) &&
      (target_o == flash_guard_pkg::TGT_FLASH) && !$past(op_i[2]) |-> !key_armed_o)
      else $error("key still armed after write");
   a_flag_after: assert property (
      flash_error_reset_o && !sys_reset_i ##1 sys_reset_i |=> flash_error_flag_o)
      else $error("error flag lost over reset");
   a_lock_holds: assert property (
      state_ff.loaded && !sys_reset_i |=> $stable(locked_pages_o))
      else $error("lock changed before reset");
   a_reserved_debug: assert property (
      req_i && !sys_reset_i && op_i[2] && (op_i != flash_guard_pkg::OP_DBG_FULL) &&
      (addr_i >= flash_guard_pkg::RESERVED_BASE) &&
      (addr_i != flash_guard_pkg::PART_ID_ADDR) |=> ignored_o && !grant_o)
      else $error("debug reached reserved area");
   c_full_erase: cover property (req_i && (op_i == flash_guard_pkg::OP_DBG_FULL) ##1 grant_o);
   c_armed_write: cover property (key_armed_o ##[1:20] (grant_o && !key_armed_o));
   c_error_reset: cover property (flash_error_reset_o ##[1:20] sys_reset_i);

endmodule

//--- verif/flash_requester_model.sv
// Requester model standing in for firmware and the debug port.
`timescale 1ns/100ps
module flash_requester_model (
   input logic clk_i,
   output logic req_o,
   output flash_guard_pkg::op_t op_o,
   output logic [15:0] addr_o,
   output logic [7:0] wr_data_o,
   output logic [15:0] exec_addr_o,
   output logic key_wr_o,
   output logic [7:0] key_data_o,
   output logic sm_en_o,
   output logic sm_rst_en_o
);
   // ----------------------------------------------------------------
   // Start-up state
   // ----------------------------------------------------------------
   // The supply monitor and its reset source come up together, first thing.
   initial begin
      {req_o, key_wr_o, key_data_o, addr_o, wr_data_o, exec_addr_o} = '0;
      op_o = flash_guard_pkg::OP_FETCH;
      sm_en_o = 1'b1;
      sm_rst_en_o = 1'b1;
   end
   // One request, held through the taking edge; idle address and data lines show the inverse
   // so that a stale address can never pass for a live one.
   task automatic request(input logic [2:0] op, input logic [15:0] a,
         input logic [7:0] d, input logic [15:0] e);
      @(posedge clk_i);
      #1;
      op_o = flash_guard_pkg::op_t'(op);
      addr_o = a;
      wr_data_o = d;
      exec_addr_o = e;
      req_o = 1'b1;
      @(posedge clk_i);
      #1;
      req_o = 1'b0;
      addr_o = ~a;
      wr_data_o = ~d;
   endtask
   // One write of the key register.
   task automatic key(input logic [7:0] k);
      @(posedge clk_i);
      #1;
      key_data_o = k;
      key_wr_o = 1'b1;
      @(posedge clk_i);
      #1;
      key_wr_o = 1'b0;
      key_data_o = ~k;
   endtask
   // Firmware may later switch the supply monitor off, which is punished.
   task automatic supply(input logic a, input logic b);
      sm_en_o = a;
      sm_rst_en_o = b;
   endtask
endmodule

//--- verif/flash_security_access_guard_tb.sv
// Self-checking bench of the flash security access guard.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
   $display("mismatch at %0t got %h exp %h", $time, (a), (b)); end end
module flash_security_access_guard_tb;
   localparam logic [7:0] PID = 8'h6A; // Arbitrary value.
   logic clk = 0, rst = 1, sys = 0, sel = 0, we = 0, ee = 0, sme = 1, smr = 1;
   logic req, kwr, grant_o, ignored_o, flash_error_reset_o, fe_o, id_valid_o;
   logic flash_error_flag_o, key_armed_o;
   flash_guard_pkg::op_t op;
   flash_guard_pkg::kind_t kind_o;
   flash_guard_pkg::target_t target_o;
   logic [15:0] addr, exec, addr_o;
   logic [7:0] wd, old = 0, kd, lock = 8'hFF, cur = 8'hFF, wr_data_o, id_data_o;
   logic [7:0] locked_pages_o;
   logic sm1, sm2;
   logic [31:0] seed = 32'h2cfd0472;
   int failures = 0, samples_checked = 0, ks = 0;
   always #5 clk = ~clk;
   flash_requester_model i_host (.clk_i(clk), .req_o(req), .op_o(op), .addr_o(addr),
      .wr_data_o(wd), .exec_addr_o(exec), .key_wr_o(kwr), .key_data_o(kd),
      .sm_en_o(sm1), .sm_rst_en_o(sm2));
   flash_security_access_guard #(.PART_ID(PID)) i_dut (.clk_i(clk), .rst_i(rst),
      .sys_reset_i(sys), .req_i(req), .op_i(op), .addr_i(addr), .wr_data_i(wd),
      .old_data_i(old), .exec_addr_i(exec), .scratchpad_select_i(sel),
      .store_write_enable_i(we), .store_erase_enable_i(ee), .supply_monitor_en_i(sm1),
      .supply_monitor_reset_en_i(sm2), .lock_byte_i(lock), .key_wr_i(kwr),
      .key_data_i(kd), .grant_o(grant_o), .ignored_o(ignored_o),
      .flash_error_reset_o(flash_error_reset_o), .debug_port_full_erase_o(fe_o),
      .kind_o(kind_o), .target_o(target_o), .addr_o(addr_o), .wr_data_o(wr_data_o),
      .id_valid_o(id_valid_o), .id_data_o(id_data_o),
      .flash_error_flag_o(flash_error_flag_o), .key_armed_o(key_armed_o),
      .locked_pages_o(locked_pages_o));
   // ----------------------------------------------------------------
   // Reference model
   // ----------------------------------------------------------------
   // A page is locked below the inverted count; the lock page once any is.
   function automatic logic lkd(logic [15:0] a);
      logic [7:0] n;
      n = ~cur;
      return a[15:10] < n || (a[15:10] == 6'd62 && n != 8'h00);
   endfunction
   // Next value of the stimulus shift register.
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Outcome: 0 granted, 1 ignored, 2 error reset.
   function automatic logic [1:0] pred(logic [2:0] o, logic [15:0] a, logic [15:0] e);
      logic id, rsv, md;
      id = a == 16'hFFFE && (o == 3'h1 || o == 3'h4);
      rsv = a >= 16'hFC00;
      md = o == 3'h3 && we;
      if (id || o == 3'h0 || o == 3'h2 || o == 3'h7 || (o == 3'h3 && !we))
         return 2'd0;
      if (o[2])
         return (rsv || lkd(a)) ? 2'd1 : 2'd0;
      if (rsv || (md && ee && a[15:10] == 6'd62) || (lkd(a) && !lkd(e)) ||
            (md && a == 16'hFBFF && lock != 8'hFF) || (md && !(sme && smr)))
         return 2'd2;
      return (md && ks != 2) ? 2'd1 : 2'd0;
   endfunction
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Device reset: the lock in force is resampled and the key falls idle.
   task automatic rs();
      @(posedge clk);
      #1;
      sys = 1'b1;
      @(posedge clk);
      #1;
      sys = 1'b0;
      cur = lock;
      ks = 0;
   endtask
   task automatic tkey(input logic [7:0] k);
      i_host.key(k);
      ks = (ks == 0 && k == 8'hA5) ? 1 : (ks == 1 && k == 8'hF1) ? 2 : 3;
      `CHK(key_armed_o, ks == 2)
   endtask
   task automatic do_req(input logic [2:0] o, input logic [15:0] a, input logic [15:0] e);
      logic [1:0] c;
      logic [7:0] d;
      logic id;
      flash_guard_pkg::kind_t k;
      c = pred(o, a, e);
      id = a == 16'hFFFE && (o == 3'h1 || o == 3'h4);
      k = ee ? flash_guard_pkg::KIND_ERASE : flash_guard_pkg::KIND_WRITE;
      seed = lfsr(seed);
      d = seed[15:8];
      old = seed[7:0];
      i_host.request(o, a, d, e);
      `CHK(grant_o, c == 2'd0)
      `CHK(ignored_o, c == 2'd1)
      `CHK(flash_error_reset_o, c == 2'd2)
      `CHK(addr_o, a)
      `CHK(fe_o, c == 2'd0 && o == 3'h7)
      `CHK(id_valid_o, c == 2'd0 && id)
      if (c == 0 && id) `CHK(id_data_o, PID)
      if (o == 3'h2 || (o == 3'h3 && !we)) begin
         `CHK(target_o, flash_guard_pkg::TGT_XRAM)
      end
      if (c == 0 && o == 3'h3 && we) begin
         `CHK(kind_o, k)
         if (!ee) `CHK(wr_data_o, d & old)
      end
      if (o == 3'h3 && we && c != 2) ks = (ks == 2) ? 0 : 3;
      if (c == 2) begin
         rs();
         `CHK(flash_error_flag_o, 1'b1)
      end
   endtask
   task automatic give_verdict();
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] tbl [4] = '{8'hFF, 8'hFD, 8'hC0, 8'h00};
      logic [31:0] r;
      repeat (10) @(posedge clk);
      #1;
      rst = 0;
      repeat (2) @(posedge clk);
      #1;
      // Keyed write, then a second write that needs a fresh key.
      we = 1;
      tkey(8'hA5);
      tkey(8'hF1);
      do_req(3'h3, 16'h1000, 16'h2000);
      do_req(3'h3, 16'h1004, 16'h2000);
      tkey(8'hA5);
      tkey(8'hF1);
      rs();
      tkey(8'hF1);
      tkey(8'hA5);
      rs();
      ee = 1;
      tkey(8'hA5);
      tkey(8'hF1);
      do_req(3'h3, 16'h2000, 16'h2000);
      sme = 0;
      i_host.supply(sme, smr);
      do_req(3'h3, 16'h2400, 16'h2000);
      sme = 1;
      i_host.supply(sme, smr);
      we = 0;
      do_req(3'h3, 16'h1000, 16'h2000);
      sel = 1;
      do_req(3'h1, 16'h0100, 16'h2000);
      `CHK(target_o, flash_guard_pkg::TGT_SCRATCH)
      do_req(3'h0, 16'h0100, 16'h2000);
      `CHK(target_o, flash_guard_pkg::TGT_FLASH)
      sel = 0;
      do_req(3'h7, 16'h0000, 16'h0000);
      do_req(3'h4, 16'hFFFE, 16'h0000);
      do_req(3'h1, 16'hFFFE, 16'h0000);
      // Lock phases with random traffic; a new lock waits for reset.
      foreach (tbl[p]) begin
         lock = tbl[p];
         do_req(3'h4, 16'h0100, 16'h0000);
         `CHK(locked_pages_o, ~cur)
         rs();
         `CHK(locked_pages_o, ~lock)
         repeat (60) begin
            seed = lfsr(seed);
            r = seed;
            {we, ee, sme, smr} = {r[3], r[4], r[5] | r[6], r[7] | r[8]};
            i_host.supply(sme, smr);
            do_req(r[2:0], r[29:26] == 0 ? 16'hFFFE : {r[31:30] == 0 ? 6'd62 :
               r[31:30] == 1 ? 6'd63 : r[15:10], r[25:16]}, {r[13:0], 2'b0} & 16'hF7FF);
         end
      end
      give_verdict();
   end
   // A hang is cut short and counted.
   initial begin
      #500000;
      failures++;
      give_verdict();
   end
endmodule
